//--- hdl/crci_top.sv
`timescale 1ns/1ps
`include "crci_regs.svh"

module crci_top #(
  parameter bit HAS_PLL_B = 1'b1,
  parameter bit HAS_PLL_C = 1'b1
) (
  // Clock and reset
  input  wire logic              clk,
  input  wire logic              srst,
  // Register port
  input  wire crci_pkg::crci_addr_t regAddr,
  input  wire crci_pkg::crci_word_t regWdata,
  input  wire logic              regWr,
  input  wire logic              regRd,
  output crci_pkg::crci_word_t   regRdata,
  // Ready levels from oscillators and PLLs
  input  wire crci_pkg::crci_src_t srcReady,
  // Clock security
  input  wire logic              extFastOscFail,
  input  wire logic              secMonitorEnable,
  // Interrupt lines
  output logic                   clkIrq,
  output logic                   secFailIrq
);
  import crci_pkg::*;

  // ----------------------------------------------------------------
  // Variant masks
  // ----------------------------------------------------------------

  // Absent PLLs keep their bits at zero
  localparam crci_src_t SRC_MASK = crci_src_t'(
    7'h1f | ({6'h00, HAS_PLL_B} << `CRCI_SRC_PLLB)
          | ({6'h00, HAS_PLL_C} << `CRCI_SRC_PLLC));

  // ----------------------------------------------------------------
  // Input synchronisers
  // ----------------------------------------------------------------

  logic [7:0] sync1_q;
  logic [7:0] sync2_q;
  logic [7:0] sync3_q;
  logic [7:0] stable_q;
  logic [7:0] agree;
  logic [7:0] rise;

  // Three stages; the first feeds only the second
  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      sync1_q <= `CRCI_SYNC_RST;
      sync2_q <= `CRCI_SYNC_RST;
      sync3_q <= `CRCI_SYNC_RST;
    end
    else
    begin
      sync1_q <= {extFastOscFail, srcReady};
      sync2_q <= sync1_q;
      sync3_q <= sync2_q;
    end
  end

  // A change counts once stages two and three agree
  assign agree = ~(sync2_q ^ sync3_q);

  // Filtered level, moves only on agreement
  always_ff @(posedge clk)
  begin
    if (srst)
      stable_q <= `CRCI_SYNC_RST;
    else
      stable_q <= (stable_q & ~agree) | (sync2_q & agree);
  end

  assign rise = agree & sync2_q & ~stable_q;

  // ----------------------------------------------------------------
  // Register decode
  // ----------------------------------------------------------------

  logic      ctrlHit;
  logic      ctrlWr;
  crci_src_t clrBits;
  crci_src_t enWrite;
  logic      secClr;

  assign ctrlHit = (regAddr == `CRCI_CTRL_OFS);
  assign ctrlWr  = regWr & ctrlHit;
  assign clrBits = ctrlWr ? regWdata[`CRCI_CLR_LSB +: 7] : 7'h00;
  assign secClr  = ctrlWr & regWdata[`CRCI_SECC_BIT];
  assign enWrite = regWdata[`CRCI_EN_LSB +: 7];

  // ----------------------------------------------------------------
  // Interrupt enables
  // ----------------------------------------------------------------

  crci_src_t en_q;

  // enables load on a write, reset zero
  always_ff @(posedge clk)
  begin
    if (srst)
      en_q <= `CRCI_EN_RST;
    else if (ctrlWr)
      en_q <= enWrite & SRC_MASK;
  end

  // ----------------------------------------------------------------
  // Ready flags
  // ----------------------------------------------------------------

  crci_src_t flag_q;
  crci_src_t flag_d;
  crci_src_t readySet;

  assign readySet = rise[6:0] & SRC_MASK;

  // set beats clear in the same cycle
  assign flag_d = (flag_q & ~clrBits) | readySet;

  always_ff @(posedge clk)
  begin
    if (srst)
      flag_q <= `CRCI_FLAG_RST;
    else
      flag_q <= flag_d;
  end

  // ----------------------------------------------------------------
  // Clock security
  // ----------------------------------------------------------------

  logic secActive;
  logic secSet;
  logic secFlag_q;
  logic secFlag_d;

  // detector runs only when enabled and oscillator ready
  assign secActive = secMonitorEnable & stable_q[`CRCI_SRC_EXTFAST];
  assign secSet    = secActive & rise[7];
  assign secFlag_d = (secFlag_q & ~secClr) | secSet;

  always_ff @(posedge clk)
  begin
    if (srst)
      secFlag_q <= 1'b0;
    else
      secFlag_q <= secFlag_d;
  end

  // ----------------------------------------------------------------
  // Interrupt outputs
  // ----------------------------------------------------------------

  // clock request while a ready flag meets its enable
  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      clkIrq     <= 1'b0;
      secFailIrq <= 1'b0;
    end
    else
    begin
      clkIrq     <= |(flag_d & en_q);
      secFailIrq <= secFlag_d;   // Not maskable, flag alone drives it
    end
  end

  // ----------------------------------------------------------------
  // Read port
  // ----------------------------------------------------------------

  crci_word_t readWord;

  // clear and reserved bits stay zero
  always_comb
  begin
    readWord = `CRCI_DATA_RST;
    readWord[`CRCI_FLAG_LSB +: 7] = flag_q;
    readWord[`CRCI_SECF_BIT]      = secFlag_q;
    readWord[`CRCI_EN_LSB +: 7]   = en_q;
  end

  // Data valid only in the cycle after the strobe
  always_ff @(posedge clk)
  begin
    if (srst)
      regRdata <= `CRCI_DATA_RST;
    else if (regRd && ctrlHit)
      regRdata <= readWord;
    else
      regRdata <= `CRCI_DATA_RST;  // Unmapped reads return zero
  end

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------

  default clocking cb @(posedge clk); endclocking
  default disable iff (srst);

  property p_secClear;
    (secClr && !secSet) |=> !secFlag_q;
  endproperty
  a_secClear: assert property (p_secClear)
    else $error("security flag survived its clear");

  property p_readyClear;
    ctrlWr |=> ((flag_q & $past(clrBits) & ~$past(readySet)) == 7'h00);
  endproperty
  a_readyClear: assert property (p_readyClear)
    else $error("ready flag survived its clear");

  property p_enHold;
    !ctrlWr |=> $stable(en_q);
  endproperty
  a_enHold: assert property (p_enHold)
    else $error("enable changed without a write");

  property p_enLoad;
    ctrlWr |=> (en_q == ($past(enWrite) & SRC_MASK));
  endproperty
  a_enLoad: assert property (p_enLoad)
    else $error("enable did not take written value");

  property p_flagSticky;
    (clrBits == 7'h00) |=> (($past(flag_q) & ~flag_q) == 7'h00);
  endproperty
  a_flagSticky: assert property (p_flagSticky)
    else $error("ready flag fell without a clear");

  property p_readySet;
    (readySet != 7'h00) |=> ((flag_q & $past(readySet)) == $past(readySet));
  endproperty
  a_readySet: assert property (p_readySet)
    else $error("ready edge did not set its flag");

  property p_edgeLatency;
    $rose(sync3_q[0]) && sync2_q[0] |-> flag_q[0] || (flag_d[0]);
  endproperty
  a_edgeLatency: assert property (p_edgeLatency)
    else $error("slow internal ready edge missed");

  property p_irqLevel;
    ##1 (clkIrq == |($past(flag_d) & $past(en_q)));
  endproperty
  a_irqLevel: assert property (p_irqLevel)
    else $error("clock interrupt does not follow flags and enables");

  property p_secGate;
    $rose(secFlag_q) |-> $past(secActive) && $past(rise[7]);
  endproperty
  a_secGate: assert property (p_secGate)
    else $error("security flag set while detector off");

  property p_secIrq;
    secFlag_q |-> secFailIrq;
  endproperty
  a_secIrq: assert property (p_secIrq)
    else $error("failure flag without its interrupt");

  property p_readZero;
    regRd |=> (regRdata[31:16] == 16'h0000) && !regRdata[15];
  endproperty
  a_readZero: assert property (p_readZero)
    else $error("clear or reserved bit read as one");

  property p_readOnce;
    !(regRd && ctrlHit) |=> (regRdata == `CRCI_DATA_RST);
  endproperty
  a_readOnce: assert property (p_readOnce)
    else $error("read data outside its cycle");

  // Main scenarios
  c_flagSet:   cover property (readySet != 7'h00 ##1 flag_q != 7'h00);
  c_setVsClr:  cover property ((readySet & clrBits) != 7'h00);
  c_secFail:   cover property ($rose(secFlag_q));
  c_irqRaised: cover property ($rose(clkIrq));

endmodule // crci_top

//--- hdl/crci_regs.svh
`ifndef CRCI_REGS_SVH
`define CRCI_REGS_SVH

// Register offset
`define CRCI_CTRL_OFS     8'h08
// Field positions
`define CRCI_FLAG_LSB     0
`define CRCI_SECF_BIT     7
`define CRCI_EN_LSB       8
`define CRCI_CLR_LSB      16
`define CRCI_SECC_BIT     23
// Ready source indices
`define CRCI_SRC_EXTFAST  3
`define CRCI_SRC_PLLB     5
`define CRCI_SRC_PLLC     6
// Reset values
`define CRCI_FLAG_RST     7'h00
`define CRCI_EN_RST       7'h00
`define CRCI_SYNC_RST     8'h00
`define CRCI_DATA_RST     32'h0000_0000
`endif

//--- hdl/crci_pkg.sv
package crci_pkg;
  // Bus data and address types
  typedef logic [31:0] crci_word_t;
  typedef logic [7:0]  crci_addr_t;
  // One bit per ready source, low to high
  typedef logic [6:0]  crci_src_t;
endpackage

//--- verif/test_crci_top.sv
`timescale 1ns/1ps
`include "crci_regs.svh"

module test_crci_top;
  import crci_pkg::*;
  // ------
  // Signals
  // ------
  logic       clk;
  logic       srst;
  crci_addr_t regAddr;
  crci_word_t regWdata;
  logic       regWr;
  logic       regRd;
  crci_word_t regRdata;
  crci_src_t  srcReady;
  logic       extFastOscFail;
  logic       secMonitorEnable;
  logic       clkIrq;
  logic       secFailIrq;
  logic       rdSeen;
  int         nErrors;
  int         testsRun;
  int         cycles;
  crci_word_t expQ[$];
  crci_word_t en;
  crci_addr_t badAddr;

  crci_top crci_top_inst (
    .clk              (clk),
    .srst             (srst),
    .regAddr          (regAddr),
    .regWdata         (regWdata),
    .regWr            (regWr),
    .regRd            (regRd),
    .regRdata         (regRdata),
    .srcReady         (srcReady),
    .extFastOscFail   (extFastOscFail),
    .secMonitorEnable (secMonitorEnable),
    .clkIrq           (clkIrq),
    .secFailIrq       (secFailIrq)
  );

  // 50 ns period
  initial
  begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end

  // ------
  // Checking
  // ------
  task automatic chk(input string nm, input crci_word_t e, input crci_word_t g);
    testsRun++;
    if (g !== e)
    begin
      nErrors++;
      $display("[FAIL] %s expected %h seen %h", nm, e, g);
    end
  endtask

  task automatic results;
    if (nErrors == 0 && testsRun > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask

  // Read data only stands the cycle after the strobe
  always @(posedge clk) rdSeen <= regRd;
  always @(negedge clk)
    if (rdSeen === 1'b1)
      chk("regRdata", expQ.pop_front(), regRdata);

  // Hang guard, well above the expected run length
  always @(posedge clk)
  begin
    cycles++;
    if (cycles == 3000)
    begin
      nErrors++;
      results;
    end
  end

  // ------
  // Bus driver
  // ------
  task automatic wr(input crci_addr_t a, input crci_word_t d);
    @(posedge clk);
    regWr    <= 1'b1;
    regAddr  <= a;
    regWdata <= d;
    @(posedge clk);
    regWr    <= 1'b0;
  endtask

  task automatic rd(input crci_addr_t a, input crci_word_t e);
    @(posedge clk);
    regRd   <= 1'b1;
    regAddr <= a;
    expQ.push_back(e);
    @(posedge clk);
    regRd   <= 1'b0;
  endtask

  // One source: set, zero-write hold, one-write clear, irq gate
  task automatic src(input int i);
    crci_word_t f;
    f = crci_word_t'(1) << i;
    @(posedge clk);
    srcReady[i] <= 1'b1;
    repeat (5) @(posedge clk);
    @(negedge clk);
    chk("clkIrq", {31'h0, en[8+i]}, {31'h0, clkIrq});
    rd(`CRCI_CTRL_OFS, en | f);
    wr(`CRCI_CTRL_OFS, en | ($urandom & 32'h007f_0000 & ~(f << 16)));
    rd(`CRCI_CTRL_OFS, en | f);
    wr(`CRCI_CTRL_OFS, en | (f << 16));
    rd(`CRCI_CTRL_OFS, en);
    @(negedge clk);
    chk("clkIrq", 32'h0, {31'h0, clkIrq});
    srcReady[i] <= 1'b0;
    repeat (3) @(posedge clk);
  endtask

  // Failure pulse on the detector line
  task automatic failPulse;
    @(posedge clk);
    extFastOscFail <= 1'b1;
    repeat (5) @(posedge clk);
    extFastOscFail <= 1'b0;
    repeat (3) @(posedge clk);
  endtask

  // ------
  // Main sequence
  // ------
  initial
  begin
    srst = 1'b1;
    regAddr = 8'h00;
    regWdata = 32'h0;
    regWr = 1'b0;
    regRd = 1'b0;
    srcReady = 7'h00;
    extFastOscFail = 1'b0;
    secMonitorEnable = 1'b0;
    rdSeen = 1'b0;
    nErrors = 0;
    testsRun = 0;
    cycles = 0;
    en = 32'h0;
    void'($urandom(91198));
    repeat (4) @(posedge clk);
    srst <= 1'b0;
    rd(`CRCI_CTRL_OFS, 32'h0);
    // Reserved and clear bits must not stick
    wr(`CRCI_CTRL_OFS, 32'hffff_ffff);
    en = 32'h0000_7f00;
    rd(`CRCI_CTRL_OFS, en);
    // Unmapped place: reads zero, ignores writes
    badAddr = 8'h08 ^ crci_addr_t'($urandom_range(1, 255));
    wr(badAddr, 32'h0);
    rd(badAddr, 32'h0);
    rd(`CRCI_CTRL_OFS, en);
    for (int i = 0; i < 7; i++)
      src(i);
    // Masked source still flags but raises nothing
    wr(`CRCI_CTRL_OFS, 32'h0);
    en = 32'h0;
    src($urandom_range(0, 6));
    // Failure ignored while the monitor is off
    @(posedge clk);
    srcReady[3] <= 1'b1;
    repeat (5) @(posedge clk);
    wr(`CRCI_CTRL_OFS, 32'h0008_0000);
    failPulse;
    rd(`CRCI_CTRL_OFS, 32'h0);
    @(negedge clk);
    chk("secFailIrq", 32'h0, {31'h0, secFailIrq});
    secMonitorEnable <= 1'b1;
    failPulse;
    @(negedge clk);
    chk("secFailIrq", 32'h1, {31'h0, secFailIrq});
    rd(`CRCI_CTRL_OFS, 32'h0000_0080);
    wr(`CRCI_CTRL_OFS, 32'h007f_0000);
    rd(`CRCI_CTRL_OFS, 32'h0000_0080);
    wr(`CRCI_CTRL_OFS, 32'h0080_0000);
    @(negedge clk);
    chk("secFailIrq", 32'h0, {31'h0, secFailIrq});
    rd(`CRCI_CTRL_OFS, 32'h0);
    repeat (3) @(posedge clk);
    results;
  end
endmodule // test_crci_top
